// ==== sgc_switch_global_config_regs.sv ====
`timescale 1ns/1ns
module sgc_switch_global_config_regs #(
   parameter logic [15:0] ADDR_HIGH_RESET = 16'h0200,
   parameter logic [15:0] ADDR_MID_RESET = 16'h0000
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire sgc_pkg::sgc_host_req_type hostReq,
   output logic [15:0] hostReadData,
   output logic hostReadValid,
   input wire logic supplyIs1v8Pin,
   input wire logic tagValid,
   input wire logic [2:0] tagCode,
   output logic [1:0] framePriority,
   output logic framePriorityValid,
   input wire logic lookupMissValid,
   output logic [2:0] unknownDestPorts,
   output logic unknownDestValid,
   output logic [1:0] padDriveCode,
   output logic [1:0] ledMode,
   output logic [47:0] pauseStationAddress,
   input wire sgc_pkg::sgc_wake_byte_type wakeByte,
   input wire logic [31:0] wakeExpectedCrc,
   output logic wakeMatch,
   output logic wakeDone
);
   import sgc_pkg::*;

   // ADDR_HIGH_RESET and ADDR_MID_RESET defaults are arbitrary values

   logic [15:0] tagMap_reg, tagMap_next;
   logic [15:0] miscCtrl_reg, miscCtrl_next;
   logic [15:0] addrHigh_reg, addrHigh_next;
   logic [15:0] addrMid_reg, addrMid_next;
   logic [15:0] addrLow_reg, addrLow_next;
   logic [15:0] wakeMask_reg, wakeMask_next;
   logic [15:0] readData_reg, readData_next;
   logic readValid_reg, readValid_next;
   logic supplySync1_reg, supplySync2_reg;
   logic [1:0] strapCount_reg, strapCount_next;
   logic strapDone_reg, strapDone_next;
   logic driveWritten_reg, driveWritten_next;
   logic [1:0] prio_reg, prio_next;
   logic prioValid_reg, prioValid_next;
   logic [2:0] fwdPorts_reg, fwdPorts_next;
   logic fwdValid_reg, fwdValid_next;
   logic [31:0] crc_reg, crc_next;
   logic [6:0] byteIndex_reg, byteIndex_next;
   logic match_reg, match_next;
   logic done_reg, done_next;
   logic hostWrite;
   logic hostRead;

   function automatic logic [15:0] mergeBytes(input logic [15:0] oldWord,
         input logic [15:0] newWord, input logic [1:0] enables);
      logic [15:0] merged;
      merged = oldWord;
      if (enables[0]) begin
         merged[7:0] = newWord[7:0];
      end
      if (enables[1]) begin
         merged[15:8] = newWord[15:8];
      end
      return merged;
   endfunction

   function automatic logic [31:0] crcByte(input logic [31:0] crcIn, input logic [7:0] data);
      logic [31:0] crc;
      crc = crcIn;
      for (int i = 0; i < 8; i++) begin
         if (crc[0] ^ data[i]) begin
            crc = (crc >> 1) ^ CRC_POLY_REFLECTED;
         end else begin
            crc = crc >> 1;
         end
      end
      return crc;
   endfunction

   assign hostWrite = hostReq.chipSelect && hostReq.writeStrobe;
   assign hostRead = hostReq.chipSelect && hostReq.readStrobe;

   // Strap synchroniser
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         supplySync1_reg <= 1'b0;
         supplySync2_reg <= 1'b0;
      end else begin
         supplySync1_reg <= supplyIs1v8Pin;
         supplySync2_reg <= supplySync1_reg;
      end
   end

   // Register file write and read-back
   always_comb begin
      tagMap_next = tagMap_reg;
      miscCtrl_next = miscCtrl_reg;
      addrHigh_next = addrHigh_reg;
      addrMid_next = addrMid_reg;
      addrLow_next = addrLow_reg;
      wakeMask_next = wakeMask_reg;
      driveWritten_next = driveWritten_reg;
      strapCount_next = strapCount_reg;
      strapDone_next = strapDone_reg;
      readData_next = readData_reg;
      readValid_next = hostRead;
      if (!strapDone_reg) begin
         if (strapCount_reg == STRAP_CAPTURE_CYCLES) begin
            strapDone_next = 1'b1;
            if (!driveWritten_reg) begin
               miscCtrl_next[DRIVE_STRENGTH_LSB +: 2] = supplySync2_reg ?
                  DRIVE_CODE_SUPPLY_LOW : DRIVE_CODE_SUPPLY_HIGH;
            end
         end else begin
            strapCount_next = strapCount_reg + 2'h1;
         end
      end
      if (hostWrite) begin
         case (hostReq.address)
            TAG_PRIORITY_MAP_OFFSET: begin
               tagMap_next = mergeBytes(tagMap_reg, hostReq.writeData,
                  hostReq.byteEnable);
            end
            SWITCH_MISC_CONTROL_OFFSET: begin
               miscCtrl_next = mergeBytes(miscCtrl_next, hostReq.writeData,
                  hostReq.byteEnable);
               if (hostReq.byteEnable[0]) begin
                  driveWritten_next = 1'b1;
               end
            end
            PAUSE_SOURCE_ADDR_HIGH_OFFSET: begin
               addrHigh_next = mergeBytes(addrHigh_reg, hostReq.writeData, hostReq.byteEnable);
            end
            PAUSE_SOURCE_ADDR_MID_OFFSET: begin
               addrMid_next = mergeBytes(addrMid_reg, hostReq.writeData, hostReq.byteEnable);
            end
            PAUSE_SOURCE_ADDR_LOW_OFFSET: begin
               addrLow_next = mergeBytes(addrLow_reg, hostReq.writeData, hostReq.byteEnable);
            end
            WAKE_PATTERN2_MASK_WORD3_OFFSET: begin
               wakeMask_next = mergeBytes(wakeMask_reg, hostReq.writeData, hostReq.byteEnable);
            end
            default: begin
            end
         endcase
      end
      if (hostRead) begin
         case (hostReq.address)
            TAG_PRIORITY_MAP_OFFSET: readData_next = tagMap_reg;
            SWITCH_MISC_CONTROL_OFFSET: readData_next = miscCtrl_reg;
            PAUSE_SOURCE_ADDR_HIGH_OFFSET: readData_next = addrHigh_reg;
            PAUSE_SOURCE_ADDR_MID_OFFSET: readData_next = addrMid_reg;
            PAUSE_SOURCE_ADDR_LOW_OFFSET: readData_next = addrLow_reg;
            WAKE_PATTERN2_MASK_WORD3_OFFSET: readData_next = wakeMask_reg;
            default: readData_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tagMap_reg <= TAG_PRIORITY_MAP_RESET;
         miscCtrl_reg <= SWITCH_MISC_CONTROL_RESET;
         addrHigh_reg <= ADDR_HIGH_RESET;
         addrMid_reg <= ADDR_MID_RESET;
         addrLow_reg <= PAUSE_SOURCE_ADDR_LOW_RESET;
         wakeMask_reg <= WAKE_MASK_WORD3_RESET;
         driveWritten_reg <= 1'b0;
         strapCount_reg <= 2'h0;
         strapDone_reg <= 1'b0;
         readData_reg <= 16'h0000;
         readValid_reg <= 1'b0;
      end else begin
         tagMap_reg <= tagMap_next;
         miscCtrl_reg <= miscCtrl_next;
         addrHigh_reg <= addrHigh_next;
         addrMid_reg <= addrMid_next;
         addrLow_reg <= addrLow_next;
         wakeMask_reg <= wakeMask_next;
         driveWritten_reg <= driveWritten_next;
         strapCount_reg <= strapCount_next;
         strapDone_reg <= strapDone_next;
         readData_reg <= readData_next;
         readValid_reg <= readValid_next;
      end
   end

   // Priority lookup and unknown-destination forwarding
   always_comb begin
      prioValid_next = tagValid;
      prio_next = tagValid ? tagMap_reg[{tagCode, 1'b0} +: 2] : prio_reg;
      fwdValid_next = lookupMissValid;
      fwdPorts_next = fwdPorts_reg;
      if (lookupMissValid) begin
         fwdPorts_next = miscCtrl_reg[UNKNOWN_FWD_ENABLE_BIT] ?
            miscCtrl_reg[UNKNOWN_PORTS_LSB +: PORT_COUNT] : ALL_PORTS;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prio_reg <= 2'h0;
         prioValid_reg <= 1'b0;
         fwdPorts_reg <= 3'h0;
         fwdValid_reg <= 1'b0;
      end else begin
         prio_reg <= prio_next;
         prioValid_reg <= prioValid_next;
         fwdPorts_reg <= fwdPorts_next;
         fwdValid_reg <= fwdValid_next;
      end
   end

   // Wake-up pattern CRC over masked bytes
   always_comb begin
      crc_next = crc_reg;
      byteIndex_next = byteIndex_reg;
      match_next = 1'b0;
      done_next = 1'b0;
      if (wakeByte.frameStart) begin
         crc_next = CRC_INIT;
         byteIndex_next = 7'h00;
      end else if (wakeByte.byteValid) begin
         if (byteIndex_reg >= WAKE_WINDOW_FIRST && byteIndex_reg <= WAKE_WINDOW_LAST &&
               wakeMask_reg[byteIndex_reg[3:0]]) begin
            crc_next = crcByte(crc_reg, wakeByte.data);
         end
         if (byteIndex_reg != 7'h7f) begin
            byteIndex_next = byteIndex_reg + 7'h01;
         end
      end
      if (wakeByte.frameEnd && !wakeByte.frameStart) begin
         done_next = 1'b1;
         match_next = ~crc_next == wakeExpectedCrc;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         crc_reg <= CRC_INIT;
         byteIndex_reg <= 7'h00;
         match_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         crc_reg <= crc_next;
         byteIndex_reg <= byteIndex_next;
         match_reg <= match_next;
         done_reg <= done_next;
      end
   end

   assign hostReadData = readData_reg;
   assign hostReadValid = readValid_reg;
   assign framePriority = prio_reg;
   assign framePriorityValid = prioValid_reg;
   assign unknownDestPorts = fwdPorts_reg;
   assign unknownDestValid = fwdValid_reg;
   assign padDriveCode = miscCtrl_reg[DRIVE_STRENGTH_LSB +: 2];
   assign ledMode = miscCtrl_reg[LED_MODE_LSB +: 2];
   assign pauseStationAddress = {addrHigh_reg, addrMid_reg, addrLow_reg};
   assign wakeMatch = match_reg;
   assign wakeDone = done_reg;

   sequence tagWriteSeq;
      hostWrite && hostReq.address == TAG_PRIORITY_MAP_OFFSET && hostReq.byteEnable == 2'h3;
   endsequence
   sequence readTagSeq;
      hostRead && hostReq.address == TAG_PRIORITY_MAP_OFFSET;
   endsequence

   tag_reset_a: assert property (@(posedge core_clk) $fell(sys_rst) |->
      tagMap_reg == 16'hfa50) else $error("tag map default wrong");
   low_addr_reset_a: assert property (@(posedge core_clk) $fell(sys_rst) |->
      addrLow_reg == 16'hffff && wakeMask_reg == 16'h0000 && miscCtrl_reg[7] == 1'b0 &&
      miscCtrl_reg[2:0] == 3'h7) else $error("reset default wrong");
   tag_lookup_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      tagValid |=> framePriorityValid &&
      framePriority == $past(tagMap_reg[{tagCode, 1'b0} +: 2]))
      else $error("frame priority mismatch");
   tag_readback_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      tagWriteSeq ##2 readTagSeq |=> hostReadValid &&
      hostReadData == $past(hostReq.writeData, 3))
      else $error("tag map readback wrong");
   unknown_fwd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      lookupMissValid && miscCtrl_reg[7] |=> unknownDestValid &&
      unknownDestPorts == $past(miscCtrl_reg[2:0])) else $error("unknown port set wrong");
   flood_fwd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      lookupMissValid && !miscCtrl_reg[7] |=> unknownDestPorts == 3'h7)
      else $error("disabled unknown forward not flooded");
   drive_strap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(strapDone_reg) && !driveWritten_reg |->
      padDriveCode == ($past(supplySync2_reg) ? 2'h2 : 2'h1)) else $error("drive strap wrong");
   drive_pad_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      hostWrite && hostReq.address == SWITCH_MISC_CONTROL_OFFSET && hostReq.byteEnable[0] |=>
      padDriveCode == $past(hostReq.writeData[6:5])) else $error("pad drive not from write");
   station_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      hostWrite && hostReq.address == PAUSE_SOURCE_ADDR_HIGH_OFFSET &&
      hostReq.byteEnable == 2'h3 |=> pauseStationAddress[47:32] == $past(hostReq.writeData))
      else $error("pause address high word wrong");
   station_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      hostWrite && hostReq.address == PAUSE_SOURCE_ADDR_LOW_OFFSET &&
      hostReq.byteEnable == 2'h3 |=> pauseStationAddress[15:0] == $past(hostReq.writeData))
      else $error("pause address low word wrong");
   wake_unmasked_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      wakeByte.byteValid && !wakeByte.frameStart && byteIndex_reg < 7'h30 |=>
      crc_reg == $past(crc_reg)) else $error("byte outside mask window changed crc");
   wake_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      wakeByte.frameEnd && !wakeByte.frameStart |=>
      wakeDone ##1 (!wakeDone || $past(wakeByte.frameEnd)))
      else $error("wake done pulse wrong");
endmodule

// ==== sgc_pkg.sv ====
package sgc_pkg;
   localparam int HOST_ADDR_WIDTH = 8;
   localparam int WORD_WIDTH = 16;
   localparam int NUM_TAG_CODES = 8;
   localparam int PORT_COUNT = 3;

   // Register offsets
   localparam logic [7:0] TAG_PRIORITY_MAP_OFFSET = 8'h0c;
   localparam logic [7:0] SWITCH_MISC_CONTROL_OFFSET = 8'h0e;
   localparam logic [7:0] PAUSE_SOURCE_ADDR_HIGH_OFFSET = 8'h10;
   localparam logic [7:0] PAUSE_SOURCE_ADDR_MID_OFFSET = 8'h12;
   localparam logic [7:0] PAUSE_SOURCE_ADDR_LOW_OFFSET = 8'h14;
   localparam logic [7:0] WAKE_PATTERN2_MASK_WORD3_OFFSET = 8'h5a;

   // Field positions in the misc control word
   localparam int LED_MODE_LSB = 8;
   localparam int UNKNOWN_FWD_ENABLE_BIT = 7;
   localparam int DRIVE_STRENGTH_LSB = 5;
   localparam int UNKNOWN_PORTS_LSB = 0;

   // Values after reset, strap drive codes and the flood port set
   localparam logic [15:0] TAG_PRIORITY_MAP_RESET = 16'hfa50;
   localparam logic [15:0] SWITCH_MISC_CONTROL_RESET = 16'h0827;
   localparam logic [15:0] PAUSE_SOURCE_ADDR_LOW_RESET = 16'hffff;
   localparam logic [15:0] WAKE_MASK_WORD3_RESET = 16'h0000;
   localparam logic [1:0] DRIVE_CODE_SUPPLY_HIGH = 2'h1;
   localparam logic [1:0] DRIVE_CODE_SUPPLY_LOW = 2'h2;
   localparam logic [2:0] ALL_PORTS = 3'h7;

   // Wake-up byte window covered by mask word 3 (zero-based byte index)
   localparam logic [6:0] WAKE_WINDOW_FIRST = 7'h30;
   localparam logic [6:0] WAKE_WINDOW_LAST = 7'h3f;
   localparam logic [31:0] CRC_POLY_REFLECTED = 32'hedb8_8320;
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

   // Strap capture delay after reset release
   localparam logic [1:0] STRAP_CAPTURE_CYCLES = 2'h2;

   typedef struct packed {
      logic chipSelect;
      logic writeStrobe;
      logic readStrobe;
      logic [7:0] address;
      logic [1:0] byteEnable;
      logic [15:0] writeData;
   } sgc_host_req_type;

   typedef struct packed {
      logic frameStart;
      logic byteValid;
      logic frameEnd;
      logic [7:0] data;
   } sgc_wake_byte_type;
endpackage

// ==== sgc_switch_global_config_regs_tb.sv ====
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin fails++; $display("mismatch at %0t: %s", $time, msg); end end
module sgc_switch_global_config_regs_tb;
   import sgc_pkg::*;
   localparam logic [15:0] HIGH_RST = 16'h5a3c; // Arbitrary value
   localparam logic [15:0] MID_RST = 16'h1e2d; // Arbitrary value
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   sgc_host_req_type hostReq = '0;
   logic supplyIs1v8Pin = 1'b0;
   logic tagValid = 1'b0;
   logic [2:0] tagCode = 3'h0;
   logic lookupMissValid = 1'b0;
   sgc_wake_byte_type wakeByte = '0;
   logic [31:0] wakeExpectedCrc = 32'h0000_0000;
   logic [15:0] hostReadData;
   logic hostReadValid, framePriorityValid, unknownDestValid, wakeMatch, wakeDone;
   logic [1:0] framePriority, padDriveCode, ledMode;
   logic [2:0] unknownDestPorts;
   logic [47:0] pauseStationAddress;
   int fails = 0;
   int total_checks = 0;
   logic [15:0] rdQ[$];
   logic [1:0] prQ[$];
   logic [2:0] udQ[$];
   logic wkQ[$];
   logic [7:0] frame[64];

   always #20 core_clk = ~core_clk;

   sgc_switch_global_config_regs #(.ADDR_HIGH_RESET(HIGH_RST), .ADDR_MID_RESET(MID_RST)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .hostReq(hostReq), .hostReadData(hostReadData),
      .hostReadValid(hostReadValid), .supplyIs1v8Pin(supplyIs1v8Pin), .tagValid(tagValid),
      .tagCode(tagCode), .framePriority(framePriority), .framePriorityValid(framePriorityValid),
      .lookupMissValid(lookupMissValid), .unknownDestPorts(unknownDestPorts),
      .unknownDestValid(unknownDestValid), .padDriveCode(padDriveCode), .ledMode(ledMode),
      .pauseStationAddress(pauseStationAddress), .wakeByte(wakeByte),
      .wakeExpectedCrc(wakeExpectedCrc), .wakeMatch(wakeMatch), .wakeDone(wakeDone));

   // Result watcher
   always @(negedge core_clk) begin
      if (!sys_rst) begin
         if (hostReadValid === 1'b1 && rdQ.size() > 0) `CHK(hostReadData, rdQ.pop_front(), "read data")
         else if (hostReadValid !== 1'b0) `CHK(1'b1, 1'b0, "unexpected read answer")
         if (framePriorityValid === 1'b1 && prQ.size() > 0) `CHK(framePriority, prQ.pop_front(), "priority")
         else if (framePriorityValid !== 1'b0) `CHK(1'b1, 1'b0, "unexpected priority")
         if (unknownDestValid === 1'b1 && udQ.size() > 0) `CHK(unknownDestPorts, udQ.pop_front(), "ports")
         else if (unknownDestValid !== 1'b0) `CHK(1'b1, 1'b0, "unexpected ports")
         if (wakeDone === 1'b1 && wkQ.size() > 0) `CHK(wakeMatch, wkQ.pop_front(), "wake match")
         else if (wakeDone !== 1'b0) `CHK(1'b1, 1'b0, "unexpected wake result")
      end
   end

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic drain(input string name);
      int n;
      for (n = 0; n < 20 && rdQ.size() + prQ.size() + udQ.size() + wkQ.size() > 0; n++)
         @(posedge core_clk);
      if (rdQ.size() + prQ.size() + udQ.size() + wkQ.size() > 0) begin
         fails++;
         $display("mismatch at %0t: results missing", $time);
         end_of_test();
      end
      $display("test done: %s", name);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
      @(posedge core_clk);
      hostReq <= '{1'b1, 1'b1, 1'b0, a, be, d};
      @(posedge core_clk);
      hostReq <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge core_clk);
      hostReq <= '{1'b1, 1'b0, 1'b1, a, 2'h3, 16'h0000};
      rdQ.push_back(e);
      @(posedge core_clk);
      hostReq <= '0;
   endtask

   task automatic lookupAll(input logic [15:0] m);
      int c;
      for (c = 0; c < 8; c++) begin
         @(posedge core_clk);
         tagValid <= 1'b1;
         tagCode <= 3'(c);
         prQ.push_back(m[2*c +: 2]);
      end
      @(posedge core_clk);
      tagValid <= 1'b0;
   endtask

   task automatic miss(input logic [2:0] e);
      @(posedge core_clk);
      lookupMissValid <= 1'b1;
      udQ.push_back(e);
      @(posedge core_clk);
      lookupMissValid <= 1'b0;
   endtask

   function automatic logic [31:0] crcOf(input logic [15:0] mask);
      logic [31:0] c;
      c = 32'hffff_ffff;
      for (int i = 48; i < 64; i++)
         if (mask[i-48])
            for (int b = 0; b < 8; b++)
               c = (c >> 1) ^ ((c[0] ^ frame[i][b]) ? 32'hedb8_8320 : 32'h0000_0000);
      return ~c;
   endfunction

   task automatic sendFrame(input logic [15:0] mask, input logic good);
      int i;
      for (i = 0; i < 64; i++) frame[i] = 8'($urandom());
      @(posedge core_clk);
      wakeExpectedCrc <= good ? crcOf(mask) : ~crcOf(mask);
      wakeByte <= '{1'b1, 1'b0, 1'b0, 8'h00};
      wkQ.push_back(good);
      for (i = 0; i < 64; i++) begin
         @(posedge core_clk);
         wakeByte <= '{1'b0, 1'b1, (i == 63), frame[i]};
      end
      @(posedge core_clk);
      wakeByte <= '0;
   endtask

   initial begin
      logic [15:0] v, misc, hi, mid, lo;
      int k;
      void'($urandom(60));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(TAG_PRIORITY_MAP_OFFSET, 16'hfa50);
      rd(SWITCH_MISC_CONTROL_OFFSET, 16'h0827);
      rd(PAUSE_SOURCE_ADDR_HIGH_OFFSET, HIGH_RST);
      rd(PAUSE_SOURCE_ADDR_MID_OFFSET, MID_RST);
      rd(PAUSE_SOURCE_ADDR_LOW_OFFSET, 16'hffff);
      rd(WAKE_PATTERN2_MASK_WORD3_OFFSET, 16'h0000);
      rd(8'h20, 16'h0000);
      @(negedge core_clk);
      `CHK(pauseStationAddress, {HIGH_RST, MID_RST, 16'hffff}, "reset address")
      `CHK(padDriveCode, 2'h1, "reset drive code")
      lookupAll(16'hfa50);
      miss(3'h7);
      drain("reset values");
      v = 16'($urandom());
      wr(TAG_PRIORITY_MAP_OFFSET, v, 2'h3);
      rd(TAG_PRIORITY_MAP_OFFSET, v);
      lookupAll(v);
      wr(TAG_PRIORITY_MAP_OFFSET, ~v, 2'h2);
      v[15:8] = ~v[15:8];
      rd(TAG_PRIORITY_MAP_OFFSET, v);
      lookupAll(v);
      drain("priority map");
      for (k = 0; k < 8; k++) begin
         misc = 16'($urandom());
         misc[6:5] = k[1:0];
         misc[7] = k[2];
         wr(SWITCH_MISC_CONTROL_OFFSET, misc, 2'h3);
         rd(SWITCH_MISC_CONTROL_OFFSET, misc);
         miss(misc[7] ? misc[2:0] : 3'h7);
         @(negedge core_clk);
         `CHK(padDriveCode, misc[6:5], "drive code")
         `CHK(ledMode, misc[9:8], "led mode")
      end
      drain("misc control");
      hi = 16'($urandom());
      mid = 16'($urandom());
      lo = 16'($urandom());
      wr(PAUSE_SOURCE_ADDR_HIGH_OFFSET, hi, 2'h3);
      wr(PAUSE_SOURCE_ADDR_MID_OFFSET, mid, 2'h3);
      wr(PAUSE_SOURCE_ADDR_LOW_OFFSET, lo, 2'h3);
      rd(PAUSE_SOURCE_ADDR_HIGH_OFFSET, hi);
      rd(PAUSE_SOURCE_ADDR_MID_OFFSET, mid);
      rd(PAUSE_SOURCE_ADDR_LOW_OFFSET, lo);
      @(negedge core_clk);
      `CHK(pauseStationAddress, {hi, mid, lo}, "station address")
      wr(8'h20, 16'hffff, 2'h3);
      rd(8'h20, 16'h0000);
      drain("station address");
      v = 16'($urandom());
      wr(WAKE_PATTERN2_MASK_WORD3_OFFSET, v, 2'h3);
      rd(WAKE_PATTERN2_MASK_WORD3_OFFSET, v);
      sendFrame(v, 1'b1);
      sendFrame(v, 1'b0);
      wr(WAKE_PATTERN2_MASK_WORD3_OFFSET, 16'hffff, 2'h3);
      sendFrame(16'hffff, 1'b1);
      wr(WAKE_PATTERN2_MASK_WORD3_OFFSET, 16'h0001, 2'h1);
      sendFrame(16'hff01, 1'b1);
      drain("wake crc");
      supplyIs1v8Pin <= 1'b1;
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(SWITCH_MISC_CONTROL_OFFSET, 16'h0847);
      @(negedge core_clk);
      `CHK(padDriveCode, 2'h2, "low supply drive code")
      drain("low supply reset");
      end_of_test();
   end
endmodule
